// >>> core/gpio_pkg.sv
// Package for the two port slices: register addresses, reset values,
// field positions and power modes.
// Assumes an 8-bit register port with 16-bit byte addresses.
package gpio_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register byte addresses
    localparam logic [15:0] PORT9_DATA_ADDR = 16'hFFDC;
    localparam logic [15:0] INPUT_PORT_ADDR = 16'hFFDD;
    localparam logic [15:0] PORT9_DIR_ADDR = 16'hFFEC;

    // Reset values
    localparam logic [7:0] PORT9_DATA_RESET = 8'hC0;
    localparam logic [7:0] PORT9_DIR_RESET = 8'hC0;

    // Fixed read-back values of the reserved and write-only parts
    localparam logic [1:0] PORT9_HIGH_BITS = 2'h3;
    localparam logic [0:0] PORT9_BIT5 = 1'h0;
    localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field layout
    localparam int PORT9_PINS = 5;
    localparam int INPUT_PORT_PINS = 8;
    localparam int FLASH_FIXED_BIT = 0;

    // Channel select: values below this reach the input-only pins
    localparam logic [3:0] CHANNEL_PIN_LIMIT = 4'h8;

    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_SUBACTIVE,
        MODE_SLEEP,
        MODE_SUBSLEEP,
        MODE_STANDBY,
        MODE_WATCH
    } power_mode_e;

endpackage

// >>> core/analog_pin_mask.sv
// Decodes the converter channel select into a mask of input-only pins
// taken over as analog inputs.
// Assumes channel values 0 to 7 name the input-only pins in order.
`timescale 1ns/1ns
`default_nettype none

module analog_pin_mask #(
    parameter int PINS = 8
) (
    input wire logic [3:0] converter_channel_select,
    output logic [PINS-1:0] analog_mask
);

    always_comb
    begin
        analog_mask = '0;
        for (int i = 0; i < PINS; i++)
        begin
            if (converter_channel_select < gpio_pkg::CHANNEL_PIN_LIMIT &&
                converter_channel_select == 4'(i))
            begin
                analog_mask[i] = 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> core/gpio_port9_and_input_port_b.sv
// Five-pin bidirectional port with its data and direction registers and
// eight-pin input-only port with its read register on a plain 8-bit register port.
// Assumes pins and strobes are synchronous to clock; read data appear
// the cycle after the read strobe.
// Assumes FLASH_VARIANT is fixed for a build; its pin 0 never drives high.
`timescale 1ns/1ns
`default_nettype none

module gpio_port9_and_input_port_b #(
    parameter int PORT9_PINS = gpio_pkg::PORT9_PINS,
    parameter int INPUT_PINS = gpio_pkg::INPUT_PORT_PINS,
    parameter bit FLASH_VARIANT = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    input wire gpio_pkg::power_mode_e power_mode,
    input wire logic [3:0] converter_channel_select,
    input wire logic [PORT9_PINS-1:0] bidir_pin_in,
    output logic [PORT9_PINS-1:0] bidir_pin_out,
    output logic [PORT9_PINS-1:0] bidir_pin_oe_n,
    input wire logic [INPUT_PINS-1:0] input_only_pin
);

    function automatic logic hits(input logic [15:0] a, input logic [15:0] reg_addr);
        hits = (a == reg_addr);
    endfunction

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_DATA,
        SEL_INPUT,
        SEL_DIR
    } reg_sel_e;

    // One decoder shared by the write and read paths, so they never disagree
    function automatic reg_sel_e decode_reg(input logic [15:0] a);
        reg_sel_e s;
        s = SEL_NONE;
        if (hits(a, gpio_pkg::PORT9_DATA_ADDR))
        begin
            s = SEL_DATA;
        end
        else if (hits(a, gpio_pkg::INPUT_PORT_ADDR))
        begin
            s = SEL_INPUT;
        end
        else if (hits(a, gpio_pkg::PORT9_DIR_ADDR))
        begin
            s = SEL_DIR;
        end
        decode_reg = s;
    endfunction

    // Active and subactive run the port from its registers
    function automatic logic mode_functional(input gpio_pkg::power_mode_e mode);
        logic f;
        case (mode)
            gpio_pkg::MODE_ACTIVE,
            gpio_pkg::MODE_SUBACTIVE:
            begin
                f = 1'b1;
            end
            default:
            begin
                f = 1'b0;
            end
        endcase
        mode_functional = f;
    endfunction

    function automatic logic mode_retains(input gpio_pkg::power_mode_e mode);
        logic r;
        case (mode)
            gpio_pkg::MODE_SLEEP,
            gpio_pkg::MODE_SUBSLEEP,
            gpio_pkg::MODE_WATCH:
            begin
                r = 1'b1;
            end
            default:
            begin
                r = 1'b0;
            end
        endcase
        mode_retains = r;
    endfunction

    // Full data-register byte: fixed reserved bits above the pin field
    function automatic logic [7:0] compose_port9(input logic [PORT9_PINS-1:0] view);
        logic [7:0] b;
        b = '0;
        b[PORT9_PINS-1:0] = view;
        b[5] = gpio_pkg::PORT9_BIT5[0];
        b[7:6] = gpio_pkg::PORT9_HIGH_BITS;
        compose_port9 = b;
    endfunction

    // Bits that software may change in the data register
    function automatic logic [PORT9_PINS-1:0] writable_mask();
        logic [PORT9_PINS-1:0] m;
        m = '1;
        if (FLASH_VARIANT)
        begin
            m[gpio_pkg::FLASH_FIXED_BIT] = 1'b0;
        end
        writable_mask = m;
    endfunction

    // Register state
    logic [PORT9_PINS-1:0] data_q;
    logic [PORT9_PINS-1:0] data_d;
    logic [PORT9_PINS-1:0] dir_q;
    logic [PORT9_PINS-1:0] dir_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;

    // Pin drive state
    logic [PORT9_PINS-1:0] pin_out_q;
    logic [PORT9_PINS-1:0] pin_out_d;
    logic [PORT9_PINS-1:0] pin_oe_n_q;
    logic [PORT9_PINS-1:0] pin_oe_n_d;

    logic [INPUT_PINS-1:0] analog_mask;
    logic [PORT9_PINS-1:0] port9_view;
    logic [7:0] port9_read;
    logic [7:0] input_port_read;
    logic wr_data_reg;
    logic wr_dir_reg;

    // Decoded register select and pin-mode class
    reg_sel_e reg_sel;
    logic pins_follow;
    logic pins_retain;

    analog_pin_mask #(
        .PINS(INPUT_PINS)
    ) u_analog_pin_mask (
        .converter_channel_select(converter_channel_select),
        .analog_mask(analog_mask)
    );

    assign reg_sel = decode_reg(addr);
    assign wr_data_reg = wr_strobe && (reg_sel == SEL_DATA);
    assign wr_dir_reg = wr_strobe && (reg_sel == SEL_DIR);
    assign pins_follow = mode_functional(power_mode);
    assign pins_retain = mode_retains(power_mode);

    // Register writes
    always_comb
    begin
        data_d = data_q;
        dir_d = dir_q;
        if (wr_data_reg)
        begin
            // Reserved bits live outside the stored field, so writes to them vanish
            data_d = wr_data[PORT9_PINS-1:0] & writable_mask();
        end
        if (wr_dir_reg)
        begin
            dir_d = wr_data[PORT9_PINS-1:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            data_q <= gpio_pkg::PORT9_DATA_RESET[PORT9_PINS-1:0];
            dir_q <= gpio_pkg::PORT9_DIR_RESET[PORT9_PINS-1:0];
        end
        else
        begin
            data_q <= data_d;
            dir_q <= dir_d;
        end
    end

    // Per-pin read-back view of the bidirectional port
    always_comb
    begin
        for (int i = 0; i < PORT9_PINS; i++)
        begin
            port9_view[i] = dir_q[i] ? data_q[i] : bidir_pin_in[i];
        end
        if (FLASH_VARIANT)
        begin
            port9_view[gpio_pkg::FLASH_FIXED_BIT] = 1'b0;
        end
    end

    assign port9_read = compose_port9(port9_view);

    // Analog-selected pins read zero whatever their voltage
    always_comb
    begin
        input_port_read = '0;
        input_port_read[INPUT_PINS-1:0] = input_only_pin & ~analog_mask;
    end

    // Register reads, answered one cycle after the strobe
    always_comb
    begin
        rd_data_d = '0;
        if (rd_strobe)
        begin
            case (reg_sel)
                SEL_DATA:
                begin
                    rd_data_d = port9_read;
                end
                SEL_INPUT:
                begin
                    rd_data_d = input_port_read;
                end
                SEL_DIR:
                begin
                    rd_data_d = gpio_pkg::DIR_READ_VALUE;
                end
                default:
                begin
                    rd_data_d = gpio_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rd_data_q <= '0;
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    // Pin drivers follow the power mode. Retaining modes freeze both the
    // level and the enable, so a register write made there shows only
    // once the port is functional again.
    always_comb
    begin
        pin_out_d = pin_out_q;
        pin_oe_n_d = pin_oe_n_q;
        if (pins_follow)
        begin
            pin_out_d = data_q;
            pin_oe_n_d = ~dir_q;
        end
        else if (pins_retain)
        begin
            pin_out_d = pin_out_q;
            pin_oe_n_d = pin_oe_n_q;
        end
        else
        begin
            // Standby and unused codes float the pins but keep the level
            pin_oe_n_d = '1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pin_out_q <= '0;
            pin_oe_n_q <= '1;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    assign rd_data = rd_data_q;
    assign bidir_pin_out = pin_out_q;
    assign bidir_pin_oe_n = pin_oe_n_q;

endmodule

`default_nettype wire

// >>> verification/gpio_checker.sv
// Port-level checks for the two port slices.
// Assumes FLASH_VARIANT 0 and no strobes during reset.
`timescale 1ns/1ns
`default_nettype none
module gpio_checker #(
    parameter int PORT9_PINS = 5,
    parameter int INPUT_PINS = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_data,
    input wire gpio_pkg::power_mode_e power_mode,
    input wire logic [3:0] converter_channel_select,
    input wire logic [PORT9_PINS-1:0] bidir_pin_in,
    input wire logic [PORT9_PINS-1:0] bidir_pin_out,
    input wire logic [PORT9_PINS-1:0] bidir_pin_oe_n,
    input wire logic [INPUT_PINS-1:0] input_only_pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic act;
    assign act = power_mode == gpio_pkg::MODE_ACTIVE;
    AST_DIR_READ: assert property (rd_strobe && addr == 16'hFFEC |=> rd_data == 8'hFF)
        else $error("dir read");
    AST_DATA_HIGH: assert property (rd_strobe && addr == 16'hFFDC |=> rd_data[7:5] == 3'h6)
        else $error("data high bits");
    AST_PORTB_READ: assert property (rd_strobe && addr == 16'hFFDD |=>
        rd_data == ($past(input_only_pin) & ~(8'h01 << $past(converter_channel_select))))
        else $error("input port read");
    AST_RESET_HIGHZ: assert property (disable iff (1'b0) rst |=> bidir_pin_oe_n == '1)
        else $error("reset drive");
    AST_STANDBY_HIGHZ: assert property (power_mode == gpio_pkg::MODE_STANDBY |=> &bidir_pin_oe_n)
        else $error("standby drive");
    AST_SLEEP_HOLD: assert property (power_mode == gpio_pkg::MODE_SLEEP |=>
        $stable(bidir_pin_out) && $stable(bidir_pin_oe_n))
        else $error("sleep hold");
    AST_RETAIN_HOLD: assert property ((power_mode == gpio_pkg::MODE_SUBSLEEP ||
        power_mode == gpio_pkg::MODE_WATCH) |=> $stable(bidir_pin_out) && $stable(bidir_pin_oe_n))
        else $error("retain hold");
    AST_DIR_DRIVE: assert property ((wr_strobe && addr == 16'hFFEC && act) ##1 act |=>
        bidir_pin_oe_n == ~$past(wr_data[4:0], 2))
        else $error("dir drive");
    AST_DATA_DRIVE: assert property ((wr_strobe && addr == 16'hFFDC && act) ##1 act |=>
        bidir_pin_out == $past(wr_data[4:0], 2))
        else $error("data drive");
    cover property (rd_strobe && addr == 16'hFFDD);
    cover property (wr_strobe && addr == 16'hFFEC);
    cover property (power_mode == gpio_pkg::MODE_SLEEP);
    cover property (power_mode == gpio_pkg::MODE_SUBACTIVE && wr_strobe);
endmodule
bind gpio_port9_and_input_port_b gpio_checker #(.PORT9_PINS(PORT9_PINS),
    .INPUT_PINS(INPUT_PINS)) chk_u (.clock, .rst, .addr, .wr_data, .wr_strobe,
    .rd_strobe, .rd_data, .power_mode, .converter_channel_select, .bidir_pin_in,
    .bidir_pin_out, .bidir_pin_oe_n, .input_only_pin);
`default_nettype wire

// >>> verification/tb_top.sv
// Directed bench for the two port slices over the register port.
// Assumes read data stand only in the cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock = 0, rst = 1, wr_strobe = 0, rd_strobe = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wr_data = 8'h00, rd_data, input_only_pin = 8'h00;
    logic [3:0] converter_channel_select = 4'hF;
    logic [4:0] bidir_pin_in = 5'h00, bidir_pin_out, bidir_pin_oe_n;
    gpio_pkg::power_mode_e power_mode = gpio_pkg::MODE_ACTIVE;
    int fails = 0, total_checks = 0;
    gpio_port9_and_input_port_b dut_u (.clock, .rst, .addr, .wr_data, .wr_strobe,
        .rd_strobe, .rd_data, .power_mode, .converter_channel_select, .bidir_pin_in,
        .bidir_pin_out, .bidir_pin_oe_n, .input_only_pin);
    initial
    begin
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_strobe <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd_strobe <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    task automatic pins(input logic [3:0] c, input gpio_pkg::power_mode_e m);
        @(posedge clock);
        bidir_pin_in <= 5'h04;
        input_only_pin <= 8'hA5;
        converter_channel_select <= c;
        power_mode <= m;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(16'hFFEC, 8'hFF);
        rd(16'hFFDC, 8'hC0);
        chk({3'h0, bidir_pin_oe_n}, 8'h1F);
        pins(4'hF, gpio_pkg::MODE_ACTIVE);
        wr(16'hFFDC, 8'hFF);
        wr(16'hFFEC, 8'h0A);
        wr(16'hFFDD, 8'h00);
        rd(16'hFFDC, 8'hCE);
        chk({3'h0, bidir_pin_oe_n}, 8'h15);
        chk({3'h0, bidir_pin_out}, 8'h1F);
        rd(16'hFFDD, 8'hA5);
        for (int c = 0; c < 8; c++)
        begin
            pins(c[3:0], gpio_pkg::MODE_ACTIVE);
            rd(16'hFFDD, 8'hA5 & ~(8'h01 << c));
        end
        rd(16'h1234, 8'h00);
        $display("test registers done");
        pins(4'hF, gpio_pkg::MODE_STANDBY);
        chk({3'h0, bidir_pin_oe_n}, 8'h1F);
        pins(4'hF, gpio_pkg::MODE_SLEEP);
        wr(16'hFFDC, 8'h00);
        pins(4'hF, gpio_pkg::MODE_SLEEP);
        chk({3'h0, bidir_pin_out}, 8'h1F);
        pins(4'hF, gpio_pkg::MODE_ACTIVE);
        chk({3'h0, bidir_pin_out}, 8'h00);
        chk({3'h0, bidir_pin_oe_n}, 8'h15);
        pins(4'hF, gpio_pkg::MODE_SUBACTIVE);
        wr(16'hFFDC, 8'h1B);
        pins(4'hF, gpio_pkg::MODE_WATCH);
        chk({3'h0, bidir_pin_out}, 8'h1B);
        wr(16'hFFDC, 8'h0A);
        wr(16'hFFEC, 8'h1F);
        pins(4'hF, gpio_pkg::MODE_SUBSLEEP);
        chk({3'h0, bidir_pin_out}, 8'h1B);
        chk({3'h0, bidir_pin_oe_n}, 8'h15);
        pins(4'hF, gpio_pkg::MODE_ACTIVE);
        chk({3'h0, bidir_pin_out}, 8'h0A);
        chk({3'h0, bidir_pin_oe_n}, 8'h00);
        rd(16'hFFDC, 8'hCA);
        rd(16'hFFEC, 8'hFF);
        $display("test power modes done");
        do_reset();
        rd(16'hFFDC, 8'hC4);
        chk({3'h0, bidir_pin_oe_n}, 8'h1F);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
